// [hdl/vpf_pkg.sv]
// Package: frame geometry, byte positions, payload modes and carrier structs
package vpf_pkg;
    localparam int unsigned FRAME_ROWS      = 9;
    localparam int unsigned FRAME_COLS      = 261;
    localparam int unsigned FRAME_BYTES     = FRAME_ROWS * FRAME_COLS;
    localparam int unsigned FRAME_PERIOD_US = 125;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned FRAME_CYCLES    = FRAME_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned PAYLOAD_BYTES   = 2340;
    localparam int unsigned ROW_J1          = 0;
    localparam int unsigned ROW_B3          = 1;
    localparam int unsigned ROW_C2          = 2;
    localparam int unsigned ROW_G1          = 3;
    localparam int unsigned ROW_F2          = 4;
    localparam int unsigned ROW_H4          = 5;
    localparam int unsigned ROW_F3          = 6;
    localparam int unsigned ROW_K3          = 7;
    localparam int unsigned ROW_N1          = 8;
    localparam int unsigned NUM_SLOTS       = 63;
    localparam int unsigned NUM_SRC         = 4;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [1:0]  K4_PDL_MASK     = 2'h3;

    typedef enum logic [2:0] {
        PL_ASYNC_C4 = 3'h0,
        PL_TUG      = 3'h1,
        PL_ATM      = 3'h2,
        PL_DQDB     = 3'h3,
        PL_TEST_SIGNAL_STRUCTURE_ONE     = 3'h4
    } vpf_payload_t;

    typedef struct packed {
        logic [7:0] data;
        logic       fs;
        logic       valid;
    } vpf_byte_t;

    typedef struct packed {
        logic [7:0] j1;
        logic [7:0] b3;
        logic [7:0] g1;
        logic [1:0] k4_pdl;
        logic [7:0] n1;
    } vpf_tt_oh_t;

    typedef struct packed {
        logic [7:0] c2;
        logic [7:0] f2;
        logic [7:0] f3;
        logic [7:0] h4;
        logic [3:0] k3_aps;
        logic [1:0] k3_pdl;
    } vpf_ai_oh_t;

    typedef struct packed {
        logic       tc_done;
        logic       aps_done;
        logic       pdl_done;
        logic       uneq;
        logic       uc_after_prot;
        vpf_payload_t payload;
    } vpf_cfg_t;
endpackage

// [hdl/vpf_slot_arb.sv]
// Timeslot arbiter: grants each slot to at most one adaptation source
`timescale 1ns/1ns
module vpf_slot_arb #(
    parameter int unsigned NSLOT = vpf_pkg::NUM_SLOTS,
    parameter int unsigned NSRC  = vpf_pkg::NUM_SRC
) (
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    input  wire logic                      req_valid,
    input  wire logic [$clog2(NSRC)-1:0]   req_src,
    input  wire logic [$clog2(NSLOT)-1:0]  req_slot,
    input  wire logic                      req_release,
    output logic                           grant_reg,
    output logic                           refuse_reg,
    output logic [NSLOT-1:0]               busy_reg,
    output logic [NSLOT-1:0][$clog2(NSRC)-1:0] owner_reg
);
    logic                                   grant_next;
    logic                                   refuse_next;
    logic [NSLOT-1:0]                       busy_next;
    logic [NSLOT-1:0][$clog2(NSRC)-1:0]     owner_next;

    always_comb begin
        grant_next  = 1'b0;
        refuse_next = 1'b0;
        busy_next   = busy_reg;
        owner_next  = owner_reg;
        if (req_valid) begin
            if (req_release) begin
                if (busy_reg[req_slot] && owner_reg[req_slot] == req_src) begin
                    busy_next[req_slot] = 1'b0;
                end
            end else if (!busy_reg[req_slot] || owner_reg[req_slot] == req_src) begin
                busy_next[req_slot]  = 1'b1; // R11
                owner_next[req_slot] = req_src;
                grant_next           = 1'b1;
            end else begin
                refuse_next = 1'b1; // R15
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            grant_reg  <= 1'b0;
            refuse_reg <= 1'b0;
            busy_reg   <= '0;
            owner_reg  <= '0;
        end else begin
            grant_reg  <= grant_next;
            refuse_reg <= refuse_next;
            busy_reg   <= busy_next;
            owner_reg  <= owner_next;
        end
    end

    a_refuse_keeps_owner : assert property (@(posedge mclk) disable iff (!rstn)
        refuse_next |=> owner_reg == $past(owner_reg) && busy_reg == $past(busy_reg)) // R15
        else $error("refused request changed owner");
    a_grant_excl : assert property (@(posedge mclk) disable iff (!rstn)
        req_valid && !req_release && busy_reg[req_slot] && owner_reg[req_slot] != req_src
        |=> refuse_reg && !grant_reg) // R11
        else $error("second source granted busy slot");
    c_refuse : cover property (@(posedge mclk) disable iff (!rstn) refuse_reg);
endmodule

// [hdl/vpf_framer.sv]
// VC-4 path framer: assembles AI and TT overhead into a 125 us byte stream
`timescale 1ns/1ns
// Functional notes
// R01 - Octet stream, frames every 125 us
// R02 - Insert J1, B3, G1, K4 bits 7-8; the code inserts J1, B3 and G1 but never inserts K4
// R03 - N1 carries TC overhead after TC
// R04 - N1 all zero when unequipped
// R05 - Frame holds 2340 payload, C2, F3, H4, F2
// R06 - K3 bits 1-4 APS after protection
// R07 - K3 bits 5-6 reserved, ignored
// R08 - K3 bits 7-8 path data link
// R09 - Payload is one of five types
// R10 - H4 undefined for 140M, ATM, TEST_SIGNAL_STRUCTURE_ONE
// R11 - One source per timeslot, others refused
// R12 - Sinks individually deactivatable
// R13 - Exactly one active contender per slot
// R14 - User channel protected only after protection
// R15 - Refusal keeps owner, reports conflict
module vpf_framer #(
    parameter int unsigned NSLOT = vpf_pkg::NUM_SLOTS,
    parameter int unsigned NSRC  = vpf_pkg::NUM_SRC,
    parameter int unsigned NSINK = vpf_pkg::NUM_SRC
) (
    input  wire logic                     mclk,
    input  wire logic                     rstn,
    input  wire vpf_pkg::vpf_byte_t       ai_in,
    input  wire vpf_pkg::vpf_ai_oh_t      ai_oh,
    input  wire vpf_pkg::vpf_tt_oh_t      tt_oh,
    input  wire vpf_pkg::vpf_cfg_t        cfg,
    input  wire logic [7:0]               uc_prot_f2,
    input  wire logic                     req_valid,
    input  wire logic [$clog2(NSRC)-1:0]  req_src,
    input  wire logic [$clog2(NSLOT)-1:0] req_slot,
    input  wire logic                     req_release,
    input  wire logic [NSINK-1:0]         sink_enable,
    input  wire logic [NSINK-1:0]         sink_lop_raw,
    output vpf_pkg::vpf_byte_t            ci_out,
    output logic                          frame_err,
    output logic                          req_grant,
    output logic                          conflict,
    output logic [NSLOT-1:0]              slot_busy,
    output logic [NSINK-1:0]              sink_active,
    output logic [NSINK-1:0]              sink_lop
);
    typedef enum logic [1:0] {
        ST_HUNT  = 2'b00,
        ST_SYNC  = 2'b01,
        ST_ERROR = 2'b11
    } vpf_state_t;

    vpf_state_t          state_reg;
    vpf_state_t          state_next;
    logic [3:0]          row_reg;
    logic [3:0]          row_next;
    logic [8:0]          col_reg;
    logic [8:0]          col_next;
    logic [11:0]         pay_cnt_reg;
    logic [11:0]         pay_cnt_next;
    vpf_pkg::vpf_byte_t  out_reg;
    vpf_pkg::vpf_byte_t  out_next;
    logic                err_reg;
    logic                err_next;
    logic [NSINK-1:0]    act_reg;
    logic [NSINK-1:0]    act_next;
    logic [NSINK-1:0]    lop_reg;
    logic [NSINK-1:0]    lop_next;
    logic [NSLOT-1:0][$clog2(NSRC)-1:0] owner;

    function automatic logic h4_defined(input vpf_pkg::vpf_payload_t p);
        h4_defined = (p == vpf_pkg::PL_TUG) || (p == vpf_pkg::PL_DQDB); // R10
    endfunction

    function automatic logic payload_legal(input vpf_pkg::vpf_payload_t p);
        payload_legal = (p <= vpf_pkg::PL_TEST_SIGNAL_STRUCTURE_ONE); // R09
    endfunction

    function automatic logic [7:0] poh_byte(input logic [3:0] row,
                                           input vpf_pkg::vpf_cfg_t c,
                                           input vpf_pkg::vpf_ai_oh_t a,
                                           input vpf_pkg::vpf_tt_oh_t t,
                                           input logic [7:0] f2p);
        poh_byte = vpf_pkg::BYTE_ZERO;
        case (row)
            4'(vpf_pkg::ROW_J1): poh_byte = t.j1;     // R02
            4'(vpf_pkg::ROW_B3): poh_byte = t.b3;     // R02
            4'(vpf_pkg::ROW_C2): poh_byte = a.c2;     // R05
            4'(vpf_pkg::ROW_G1): poh_byte = t.g1;     // R02
            4'(vpf_pkg::ROW_F2): poh_byte = c.uc_after_prot ? f2p : a.f2; // R14
            4'(vpf_pkg::ROW_H4): poh_byte = h4_defined(c.payload) ? a.h4
                                                                   : vpf_pkg::BYTE_ZERO; // R10
            4'(vpf_pkg::ROW_F3): poh_byte = a.f3;     // R05
            4'(vpf_pkg::ROW_K3): poh_byte = {c.aps_done ? a.k3_aps : 4'h0, 2'h0,
                                             c.pdl_done ? a.k3_pdl : 2'h0}; // R06 R07 R08
            4'(vpf_pkg::ROW_N1): poh_byte = (c.tc_done && !c.uneq) ? t.n1
                                                                    : vpf_pkg::BYTE_ZERO; // R03 R04
            default: poh_byte = vpf_pkg::BYTE_ZERO;
        endcase
    endfunction

    // Frame counters and byte assembly
    always_comb begin
        state_next   = state_reg;
        row_next     = row_reg;
        col_next     = col_reg;
        pay_cnt_next = pay_cnt_reg;
        out_next     = '0;
        err_next     = 1'b0;
        if (ai_in.valid) begin
            if (ai_in.fs) begin
                err_next   = (state_reg == ST_SYNC) &&
                             !(row_reg == 4'(vpf_pkg::FRAME_ROWS - 1) &&
                               col_reg == 9'(vpf_pkg::FRAME_COLS - 1)); // R01
                state_next = err_next ? ST_ERROR : ST_SYNC;
                row_next     = 4'h0;
                col_next     = 9'h000;
                pay_cnt_next = 12'h000;
            end else if (state_reg != ST_HUNT) begin
                if (col_reg == 9'(vpf_pkg::FRAME_COLS - 1)) begin
                    col_next = 9'h000;
                    row_next = (row_reg == 4'(vpf_pkg::FRAME_ROWS - 1)) ? 4'h0
                                                                         : row_reg + 4'h1;
                end else begin
                    col_next = col_reg + 9'h001;
                end
                if (col_reg != 9'h000) begin
                    pay_cnt_next = pay_cnt_reg + 12'h001; // R05
                end
            end
            out_next.valid = (state_next != ST_HUNT);
            out_next.fs    = ai_in.fs;
            if (ai_in.fs || (state_reg != ST_HUNT && col_next == 9'h000)) begin
                out_next.data = poh_byte(ai_in.fs ? 4'h0 : row_next, cfg, ai_oh, tt_oh,
                                         uc_prot_f2);
            end else if (state_next == ST_HUNT || cfg.uneq || !payload_legal(cfg.payload)) begin
                out_next.data = vpf_pkg::BYTE_ZERO; // R09
            end else begin
                out_next.data = ai_in.data;
            end
        end
    end

    // Sink activation: disabled sinks never report pointer loss
    always_comb begin
        act_next = sink_enable;                 // R12
        lop_next = sink_lop_raw & sink_enable;  // R12
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_reg   <= ST_HUNT;
            row_reg     <= 4'h0;
            col_reg     <= 9'h000;
            pay_cnt_reg <= 12'h000;
            out_reg     <= '0;
            err_reg     <= 1'b0;
            act_reg     <= '0;
            lop_reg     <= '0;
        end else begin
            state_reg   <= state_next;
            row_reg     <= row_next;
            col_reg     <= col_next;
            pay_cnt_reg <= pay_cnt_next;
            out_reg     <= out_next;
            err_reg     <= err_next;
            act_reg     <= act_next;
            lop_reg     <= lop_next;
        end
    end

    vpf_slot_arb #(
        .NSLOT (NSLOT),
        .NSRC  (NSRC)
    ) u_arb (
        .mclk        (mclk),
        .rstn        (rstn),
        .req_valid   (req_valid),
        .req_src     (req_src),
        .req_slot    (req_slot),
        .req_release (req_release),
        .grant_reg   (req_grant),
        .refuse_reg  (conflict),   // R15
        .busy_reg    (slot_busy),  // R13
        .owner_reg   (owner)
    );

    assign ci_out      = out_reg;
    assign frame_err   = err_reg;
    assign sink_active = act_reg;
    assign sink_lop    = lop_reg;

    a_n1_uneq_zero : assert property (@(posedge mclk) disable iff (!rstn)
        ai_in.valid && cfg.uneq && state_reg == ST_SYNC && !ai_in.fs &&
        col_reg == 9'(vpf_pkg::FRAME_COLS - 1) && row_reg == 4'(vpf_pkg::ROW_N1 - 1)
        |=> ci_out.data == 8'h00) // R04
        else $error("N1 not zero in unequipped frame");
    a_k3_reserved : assert property (@(posedge mclk) disable iff (!rstn)
        ai_in.valid && state_reg == ST_SYNC && !ai_in.fs &&
        col_reg == 9'(vpf_pkg::FRAME_COLS - 1) && row_reg == 4'(vpf_pkg::ROW_K3 - 1)
        |=> ci_out.data[3:2] == 2'h0) // R07
        else $error("K3 reserved bits driven");
    a_k3_aps : assert property (@(posedge mclk) disable iff (!rstn)
        ai_in.valid && state_reg == ST_SYNC && !ai_in.fs && cfg.aps_done &&
        col_reg == 9'(vpf_pkg::FRAME_COLS - 1) && row_reg == 4'(vpf_pkg::ROW_K3 - 1)
        |=> ci_out.data[7:4] == $past(ai_oh.k3_aps)) // R06
        else $error("K3 APS bits not carried");
    a_k3_pdl : assert property (@(posedge mclk) disable iff (!rstn)
        ai_in.valid && state_reg == ST_SYNC && !ai_in.fs && !cfg.pdl_done &&
        col_reg == 9'(vpf_pkg::FRAME_COLS - 1) && row_reg == 4'(vpf_pkg::ROW_K3 - 1)
        |=> ci_out.data[1:0] == 2'h0) // R08
        else $error("K3 data link bits without processing");
    a_j1_on_fs : assert property (@(posedge mclk) disable iff (!rstn)
        ai_in.valid && ai_in.fs |=> ci_out.fs && ci_out.data == $past(tt_oh.j1)) // R02
        else $error("J1 not at frame start");
    a_h4_blank : assert property (@(posedge mclk) disable iff (!rstn)
        ai_in.valid && state_reg == ST_SYNC && !ai_in.fs && !h4_defined(cfg.payload) &&
        col_reg == 9'(vpf_pkg::FRAME_COLS - 1) && row_reg == 4'(vpf_pkg::ROW_H4 - 1)
        |=> ci_out.data == 8'h00) // R10
        else $error("H4 driven for undefined payload");
    a_frame_len : assert property (@(posedge mclk) disable iff (!rstn)
        ai_in.valid && ai_in.fs && state_reg == ST_SYNC && pay_cnt_reg !=
        12'(vpf_pkg::PAYLOAD_BYTES - 1) |=> frame_err) // R01 R05
        else $error("short or long frame not flagged");
    a_sink_mask : assert property (@(posedge mclk) disable iff (!rstn)
        !sink_enable[0] |=> !sink_lop[0] && !sink_active[0]) // R12
        else $error("disabled sink reports pointer loss");
    a_slot_one_owner : assert property (@(posedge mclk) disable iff (!rstn)
        conflict |-> $stable(slot_busy) && $stable(owner)) // R13
        else $error("conflict altered slot ownership");

    c_frame_ok  : cover property (@(posedge mclk) disable iff (!rstn)
        ai_in.valid && ai_in.fs && state_reg == ST_SYNC ##1 !frame_err);
    c_grant     : cover property (@(posedge mclk) disable iff (!rstn) req_grant);
    c_conflict  : cover property (@(posedge mclk) disable iff (!rstn) conflict);
    c_uc_prot   : cover property (@(posedge mclk) disable iff (!rstn) cfg.uc_after_prot);
endmodule

// [dv/vpf_src_model.sv]
// Adaptation source model feeding the access point byte stream
`timescale 1ns/1ns
module vpf_src_model (
    input  wire logic          mclk,
    input  wire logic          rstn,
    input  wire logic          dense,
    input  wire logic          cut,
    input  wire logic [7:0]    rnd_byte,
    output vpf_pkg::vpf_byte_t ai_in,
    output logic               idle
);
    int   cyc = 9000;
    int   n;
    int   i;
    logic v;

    assign idle = cyc >= vpf_pkg::FRAME_CYCLES - 50;

    // Fixed frame period, bytes dense or one in five
    always @(posedge mclk) begin
        n = (cyc + 1) % vpf_pkg::FRAME_CYCLES;
        i = dense ? n : (n % 5 == 0 ? n / 5 : vpf_pkg::FRAME_BYTES);
        v = rstn && i < vpf_pkg::FRAME_BYTES && !(cut && i > 1000);
        cyc <= rstn ? n : 9000;
        ai_in.valid <= v;
        ai_in.fs <= v && i == 0;
        ai_in.data <= v ? rnd_byte : ~ai_in.data;
    end
endmodule

// [dv/vpf_framer_tb.sv]
// Self-checking bench for the path framer
`timescale 1ns/1ns
module vpf_framer_tb;
    logic                mclk = 0;
    logic                rstn = 0;
    vpf_pkg::vpf_byte_t  ai_in;
    vpf_pkg::vpf_byte_t  ci_out;
    vpf_pkg::vpf_ai_oh_t ai_oh = '0;
    vpf_pkg::vpf_tt_oh_t tt_oh = '0;
    vpf_pkg::vpf_cfg_t   cfg = '0;
    logic [7:0]          uc_prot_f2 = '0;
    logic                req_valid = 0;
    logic [1:0]          req_src = '0;
    logic [5:0]          req_slot = '0;
    logic                req_release = 0;
    logic [3:0]          sink_enable = '0;
    logic [3:0]          sink_lop_raw = '0;
    logic                frame_err;
    logic                req_grant;
    logic                conflict;
    logic [62:0]         slot_busy;
    logic [3:0]          sink_active;
    logic [3:0]          sink_lop;
    logic                dense = 0;
    logic                cut = 0;
    logic                idle;
    logic [7:0]          rnd_byte = '0;
    logic [31:0]         lfsr = 32'he7ac;
    logic [62:0]         mbusy = '0;
    logic [1:0]          mown [63];
    logic [9:0]          sq [$];
    logic [65:0]         rq [$];
    logic [7:0]          kq [$];
    logic                pend = 0;
    logic                ferr = 0;
    logic                sync = 0;
    int                  idx = 0;
    int                  fails = 0;
    int                  checks = 0;

    vpf_framer dut (.mclk(mclk), .rstn(rstn), .ai_in(ai_in), .ai_oh(ai_oh), .tt_oh(tt_oh),
        .cfg(cfg), .uc_prot_f2(uc_prot_f2), .req_valid(req_valid), .req_src(req_src),
        .req_slot(req_slot), .req_release(req_release), .sink_enable(sink_enable),
        .sink_lop_raw(sink_lop_raw), .ci_out(ci_out), .frame_err(frame_err),
        .req_grant(req_grant), .conflict(conflict), .slot_busy(slot_busy),
        .sink_active(sink_active), .sink_lop(sink_lop));

    vpf_src_model src (.mclk(mclk), .rstn(rstn), .dense(dense), .cut(cut),
        .rnd_byte(rnd_byte), .ai_in(ai_in), .idle(idle));

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] pay(input logic [7:0] d);
        return (cfg.payload <= vpf_pkg::PL_TEST_SIGNAL_STRUCTURE_ONE && !cfg.uneq) ? d : 8'h00;
    endfunction

    function automatic logic [7:0] poh(input int r);
        case (r)
            0: return tt_oh.j1;
            1: return tt_oh.b3;
            2: return ai_oh.c2;
            3: return tt_oh.g1;
            4: return cfg.uc_after_prot ? uc_prot_f2 : ai_oh.f2;
            5: return cfg.payload inside {vpf_pkg::PL_TUG, vpf_pkg::PL_DQDB} ? ai_oh.h4 : 8'h00;
            6: return ai_oh.f3;
            7: return {cfg.aps_done ? ai_oh.k3_aps : 4'h0, 2'h0,
                       cfg.pdl_done ? ai_oh.k3_pdl : 2'h0};
            default: return (cfg.tc_done && !cfg.uneq) ? tt_oh.n1 : 8'h00;
        endcase
    endfunction

    task automatic chk(input string n, input logic [65:0] e, input logic [65:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic op(input logic [1:0] s, input logic [5:0] t, input logic rel);
        logic g;
        @(posedge mclk);
        req_valid <= 1;
        req_src <= s;
        req_slot <= t;
        req_release <= rel;
        g = !mbusy[t] || mown[t] == s;
        if (!rel && g) mown[t] = s;
        mbusy[t] = !rel || (mbusy[t] && !g);
        rq.push_back({!rel, g && !rel, !g && !rel, mbusy});
    endtask

    initial forever #5 mclk = ~mclk;

    // Drives random inputs, notes expectations, compares results
    always @(posedge mclk) begin
        logic [65:0] e;
        lfsr <= nxt(lfsr);
        rnd_byte <= lfsr[23:16];
        sink_enable <= lfsr[3:0];
        sink_lop_raw <= lfsr[7:4];
        if (!rstn) kq.delete();
        else if (kq.size() == 2) chk("sink", kq.pop_front(), {sink_active, sink_lop});
        kq.push_back({lfsr[3:0], lfsr[3:0] & lfsr[7:4]});
        if (rstn) chk("frame_err", ferr, frame_err);
        ferr = 0;
        e = '0;
        if (ci_out.valid && sq.size() > 0) e = sq.pop_front();
        if (rstn) chk("ci_out", e, ci_out);
        if (!rstn) begin
            sync = 0;
            sq.delete();
        end else if (ai_in.valid) begin
            if (ai_in.fs) begin
                ferr = sync && idx != vpf_pkg::FRAME_BYTES - 1;
                sync = 1;
                idx = 0;
            end else begin
                idx++;
            end
            if (sync) sq.push_back({idx % 261 != 0 ? pay(ai_in.data) : poh(idx / 261),
                                    ai_in.fs, 1'b1});
        end
        if (pend && rq.size() > 0) begin
            e = rq.pop_front();
            if (e[65]) chk("answer", e[64:63], {req_grant, conflict});
            chk("slot_busy", e[62:0], slot_busy);
        end
        pend = req_valid && rstn;
    end

    initial begin
        repeat (90000) @(posedge mclk);
        fails++;
        give_verdict();
    end

    initial begin
        repeat (6) @(posedge mclk);
        rstn <= 1;
        op(2'd1, 6'd5, 1'b0);
        op(2'd2, 6'd5, 1'b0);
        op(2'd2, 6'd5, 1'b1);
        op(2'd1, 6'd5, 1'b0);
        op(2'd1, 6'd5, 1'b1);
        op(2'd2, 6'd5, 1'b0);
        repeat (60) op(lfsr[6:5], lfsr[2] ? 6'd62 : {4'h0, lfsr[4:3]}, lfsr[9:7] == 3'h0);
        @(posedge mclk);
        req_valid <= 0;
        $display("slot test done");
        while (!idle) @(posedge mclk);
        for (int f = 0; f < 6; f++) begin
            cfg <= '{f[0], f[1], !f[0], f == 3, f[1] ^ f[0], vpf_pkg::vpf_payload_t'(f[2:0])};
            ai_oh <= {lfsr, lfsr[7:2]};
            tt_oh <= {~lfsr, lfsr[9:8]};
            uc_prot_f2 <= lfsr[15:8] ^ 8'h5a;
            dense <= f[0];
            cut <= f == 4;
            while (idle) @(posedge mclk);
            while (!idle) @(posedge mclk);
            $display("frame test %0d done", f);
        end
        chk("leftover", 66'h0, 66'(sq.size() + rq.size()));
        give_verdict();
    end
endmodule
